// >>> mal_regs.vh
// Register offsets, field positions and codes of the MAC address lookup table.
// Assumes a 16-bit byte register address and 32-bit register data.
`ifndef MAL_REGS_VH
`define MAL_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MAL_OFS_EIDX0 16'h0400
`define MAL_OFS_EIDX1 16'h0404
`define MAL_OFS_IDX0 16'h0410
`define MAL_OFS_IDX1 16'h0414
`define MAL_OFS_CTRL 16'h0418
`define MAL_OFS_ENT1 16'h0420
`define MAL_OFS_ENT2 16'h0424
`define MAL_OFS_ENT3 16'h0428
`define MAL_OFS_ENT4 16'h042c

// ----------------------------------------------------------------------
// Access control fields
// ----------------------------------------------------------------------
`define MAL_CTL_GO 31
`define MAL_CTL_FOUND 30
`define MAL_CTL_FOD 29
`define MAL_CTL_OP_HI 28
`define MAL_CTL_OP_LO 27
`define MAL_CTL_DIRECT 26
`define MAL_OP_WRITE 2'h1
`define MAL_OP_READ 2'h2
`define MAL_OP_SEARCH 2'h3

// ----------------------------------------------------------------------
// Stored entry layout (72 bits)
// ----------------------------------------------------------------------
`define MAL_E_STATIC 71
`define MAL_E_SDROP 70
`define MAL_E_DDROP 69
`define MAL_E_AGE_HI 68
`define MAL_E_AGE_LO 66
`define MAL_E_FWD_HI 61
`define MAL_E_FWD_LO 55
`define MAL_E_FID_HI 54
`define MAL_E_FID_LO 48
`define MAL_AGE_DEFAULT 3'h7

`endif

// >>> mal_hash.v
// Hash of MAC address and optional filter group id into a bucket index.
// Assumes key and option inputs are stable in the lookup engine clock domain.
module mal_hash #(
  parameter IW = 10
) (
  // Key
  input wire [47:0] mac,
  input wire [6:0] filter_group_id,
  input wire use_fid,
  // Algorithm select
  input wire [1:0] opt,
  // Bucket index
  output reg [IW-1:0] idx
);
  integer i;
  reg [47:0] key;

  always @* begin
    key = mac ^ {41'h0, (use_fid ? filter_group_id : 7'h00)};
    idx = {IW{1'b0}};
    for (i = 0; i < 48; i = i + 1) begin
      case (opt)
        2'h0: idx[i % IW] = idx[i % IW] ^ key[i];
        2'h1: idx[(i * 7) % IW] = idx[(i * 7) % IW] ^ key[i];
        default: if (i < IW) idx[i] = key[i];
      endcase
    end
  end
endmodule // mal_hash

// >>> mal_victim.v
// Way selection within one bucket: free way, LRU dynamic victim, static count.
// Assumes rank 0 is most recently used, 3 least.
module mal_victim (
  // Bucket state
  input wire [3:0] valid,
  input wire [3:0] stat,
  input wire [7:0] rank,
  // Choice
  output reg free_ok,
  output reg [1:0] free_way,
  output reg vic_ok,
  output reg [1:0] vic_way,
  output reg [2:0] stat_cnt
);
  integer w;
  reg [1:0] best;

  always @* begin
    free_ok = 1'b0;
    free_way = 2'h0;
    vic_ok = 1'b0;
    vic_way = 2'h0;
    stat_cnt = 3'h0;
    best = 2'h0;
    for (w = 3; w >= 0; w = w - 1) begin
      if (!valid[w]) begin
        free_ok = 1'b1;
        free_way = w[1:0];
      end
      if (valid[w] && stat[w])
        stat_cnt = stat_cnt + 3'h1;
      if (valid[w] && !stat[w] && (!vic_ok || rank[w*2 +: 2] > best)) begin
        vic_ok = 1'b1;
        vic_way = w[1:0];
        best = rank[w*2 +: 2];
      end
    end
    vic_ok = vic_ok & ~free_ok;
  end
endmodule // mal_victim

// >>> mal_top.v
// MAC address lookup table: storage, host indirect access, learning, aging, DA lookup.
// Assumes all inputs come from logic on mclk; static table result arrives with dst_req.
// How it works
// - Table is 4-way, 1K buckets, 4K entries, static and dynamic share storage.
// - MAC (optionally with filter id) hashes to a 10-bit bucket index.
// - New entry fills a free way; full bucket overwrites LRU dynamic entry.
// - Destination lookup uses all tables; source lookup only this one, for learning.
// - Static destination result beats any dynamic result in forwarding.
// - Aging never touches static entries.
// - Adding a static to bucket with 2-3 statics pulses almost-full, stores address.
// - Static write to bucket of four statics fails, pulses, stores bucket index.
// - Four statics block learning; learn-fail pulses, bucket index in second register.
// - Reads see all entries; only static writes accepted; hashed, direct, search.
// - Hashed host access uses the forwarding hash with the selected option.
// - Op codes read 10, write 01, search 11; direct bit; go starts.
// - Read completion clears go, then found tells if an entry was located.
// - Found-or-done bit is high when found is set or go is clear.
// - Failed read leaves all four entry words zero.
// - Search starts at top, clears found, skips invalid, sets found per entry.
// - Reading entry word four during search resumes the scan.
// - Go stays set until all entries returned; writing go 0 aborts.
// - Word one: bit 31 static, 30 source drop, 29 destination drop, 2:0 group.
// - Bits 28:26 priority or age; reload on learn, decrement on aging.
`include "mal_regs.vh"
module mal_top #(
  parameter BKT_W = 10
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Register port
  input wire [15:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output wire [31:0] reg_rdata,
  // Lookup engine settings
  input wire [1:0] hash_option,
  input wire vlan_en,
  // Source learning
  input wire learn_req,
  input wire [47:0] learn_mac,
  input wire [6:0] learn_fid,
  input wire [2:0] learn_port,
  output wire learn_ack,
  output wire src_drop,
  // Destination lookup
  input wire dst_req,
  input wire [47:0] dst_mac,
  input wire [6:0] dst_fid,
  input wire sat_hit,
  input wire [6:0] sat_fwd,
  output wire dst_done,
  output wire dst_hit,
  output wire dst_static,
  output wire dst_drop,
  output wire [6:0] dst_fwd,
  // Aging
  input wire age_tick,
  // Events
  output wire almost_full,
  output wire write_fail,
  output wire learn_fail
);
  localparam AW = BKT_W + 2;
  localparam DEPTH = 1 << AW;
  localparam EW = 72;
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_SRCH = 4'h2;
  localparam [3:0] S_SHOW = 4'h4;
  localparam [3:0] S_AGE = 4'h8;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function ent_ok;
    input [EW-1:0] e;
    begin
      ent_ok = e[`MAL_E_STATIC] | (e[`MAL_E_AGE_HI:`MAL_E_AGE_LO] != 3'h0);
    end
  endfunction

  function [2:0] find_way;
    input [4*EW-1:0] b;
    input [47:0] mac;
    input [6:0] filter_group_id;
    input use_fid;
    integer w;
    reg [EW-1:0] e;
    begin
      find_way = 3'h0;
      for (w = 3; w >= 0; w = w - 1) begin
        e = b[w*EW +: EW];
        if (ent_ok(e) && e[47:0] == mac &&
            (!use_fid || e[`MAL_E_FID_HI:`MAL_E_FID_LO] == filter_group_id))
          find_way = {1'b1, w[1:0]};
      end
    end
  endfunction

  function [7:0] touch;
    input [7:0] r;
    input [1:0] w;
    integer i;
    reg [1:0] rw;
    begin
      rw = r[w*2 +: 2];
      touch = r;
      for (i = 0; i < 4; i = i + 1) begin
        if (r[i*2 +: 2] < rw)
          touch[i*2 +: 2] = r[i*2 +: 2] + 2'h1;
      end
      touch[w*2 +: 2] = 2'h0;
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [EW-1:0] mem_ff [0:DEPTH-1];
  reg [7:0] lru_ff [0:(1<<BKT_W)-1];
  reg [3:0] st_ff;
  reg go_ff, found_ff, dir_ff;
  reg [1:0] op_ff;
  reg [6:0] idx_fid_ff;
  reg [15:0] idx_hi_ff;
  reg [31:0] idx_lo_ff;
  reg [EW-1:0] ent_ff;
  reg [AW-1:0] eidx0_ff, ptr_ff;
  reg [BKT_W-1:0] eidx1_ff;
  reg [12:0] cnt_ff;
  reg [31:0] rdata_ff;
  reg learn_ack_ff, src_drop_ff, almost_ff, wfail_ff, lfail_ff;
  reg dst_done_ff, dst_hit_ff, dst_static_ff, dst_drop_ff;
  reg [6:0] dst_fwd_ff;
  integer k;
  integer j;

  // ----------------------------------------------------------------------
  // Engine bucket selection
  // ----------------------------------------------------------------------
  wire host_go = go_ff & st_ff[0];
  wire host_wr = (op_ff == `MAL_OP_WRITE);
  wire direct = host_go & dir_ff;
  wire [AW-1:0] dir_addr = idx_lo_ff[AW-1:0];
  wire [6:0] learn_fwd = 7'h01 << learn_port;
  reg [47:0] k_mac;
  reg [6:0] k_fid;
  always @* begin
    if (host_go && host_wr) begin
      k_mac = ent_ff[47:0];
      k_fid = ent_ff[`MAL_E_FID_HI:`MAL_E_FID_LO];
    end else if (host_go) begin
      k_mac = {idx_hi_ff, idx_lo_ff};
      k_fid = idx_fid_ff;
    end else begin
      k_mac = learn_mac;
      k_fid = learn_fid;
    end
  end

  wire [BKT_W-1:0] k_hash;
  mal_hash #(.IW(BKT_W)) u_khash (
    .mac(k_mac),
    .filter_group_id(k_fid),
    .use_fid(vlan_en),
    .opt(hash_option),
    .idx(k_hash)
  );

  wire [BKT_W-1:0] bkt = direct ? dir_addr[AW-1:2] : k_hash;
  wire [4*EW-1:0] bk = {mem_ff[{bkt, 2'h3}], mem_ff[{bkt, 2'h2}],
                        mem_ff[{bkt, 2'h1}], mem_ff[{bkt, 2'h0}]};
  wire [2:0] hit = find_way(bk, k_mac, k_fid, vlan_en);
  reg [3:0] bk_val, bk_st;
  always @* begin
    for (j = 0; j < 4; j = j + 1) begin
      bk_val[j] = ent_ok(bk[j*EW +: EW]);
      bk_st[j] = bk[j*EW + `MAL_E_STATIC];
    end
  end

  wire free_ok, vic_ok;
  wire [1:0] free_way, vic_way;
  wire [2:0] st_cnt;
  mal_victim u_victim (
    .valid(bk_val),
    .stat(bk_st),
    .rank(lru_ff[bkt]),
    .free_ok(free_ok),
    .free_way(free_way),
    .vic_ok(vic_ok),
    .vic_way(vic_way),
    .stat_cnt(st_cnt)
  );

  reg [1:0] tgt;
  reg tgt_ok;
  always @* begin
    tgt_ok = 1'b1;
    tgt = dir_addr[1:0];
    if (!direct) begin
      if (hit[2])
        tgt = hit[1:0];
      else if (free_ok)
        tgt = free_way;
      else if (vic_ok)
        tgt = vic_way;
      else
        tgt_ok = 1'b0;
    end
  end
  wire [EW-1:0] tgt_e = bk[tgt*EW +: EW];
  wire rd_ok = direct ? ent_ok(tgt_e) : hit[2];
  wire [EW-1:0] pe = mem_ff[ptr_ff];
  wire ptr_end = (ptr_ff == {AW{1'b1}});
  wire ent4_rd = reg_rd && (reg_addr == `MAL_OFS_ENT4);

  // ----------------------------------------------------------------------
  // Engine and registers
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (k = 0; k < DEPTH; k = k + 1)
        mem_ff[k] <= {EW{1'b0}};
      for (k = 0; k < (1 << BKT_W); k = k + 1)
        lru_ff[k] <= 8'he4;
      st_ff <= S_IDLE;
      go_ff <= 1'b0;
      found_ff <= 1'b0;
      dir_ff <= 1'b0;
      op_ff <= 2'h0;
      idx_fid_ff <= 7'h00;
      idx_hi_ff <= 16'h0000;
      idx_lo_ff <= 32'h00000000;
      ent_ff <= {EW{1'b0}};
      eidx0_ff <= {AW{1'b0}};
      eidx1_ff <= {BKT_W{1'b0}};
      ptr_ff <= {AW{1'b0}};
      cnt_ff <= 13'h0000;
      learn_ack_ff <= 1'b0;
      src_drop_ff <= 1'b0;
      almost_ff <= 1'b0;
      wfail_ff <= 1'b0;
      lfail_ff <= 1'b0;
    end else begin
      learn_ack_ff <= 1'b0;
      almost_ff <= 1'b0;
      wfail_ff <= 1'b0;
      lfail_ff <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (host_go) begin
            go_ff <= 1'b0;
            case (op_ff)
              `MAL_OP_READ: begin
                ent_ff <= rd_ok ? tgt_e : {EW{1'b0}};
                found_ff <= rd_ok;
              end
              `MAL_OP_WRITE: begin
                if (ent_ff[`MAL_E_STATIC]) begin
                  if (!tgt_ok) begin
                    wfail_ff <= 1'b1;
                    eidx0_ff <= {2'h0, bkt};
                  end else begin
                    mem_ff[{bkt, tgt}] <= ent_ff;
                    lru_ff[bkt] <= touch(lru_ff[bkt], tgt);
                    if (!tgt_e[`MAL_E_STATIC] && (st_cnt == 3'h2 || st_cnt == 3'h3)) begin
                      almost_ff <= 1'b1;
                      eidx0_ff <= {bkt, tgt};
                    end
                  end
                end
              end
              `MAL_OP_SEARCH: begin
                go_ff <= 1'b1;
                found_ff <= 1'b0;
                ptr_ff <= {AW{1'b0}};
                cnt_ff <= 13'h0000;
                st_ff <= S_SRCH;
              end
              default: go_ff <= 1'b0;
            endcase
          end else if (learn_req) begin
            learn_ack_ff <= 1'b1;
            src_drop_ff <= 1'b0;
            if (hit[2]) begin
              src_drop_ff <= tgt_e[`MAL_E_SDROP];
              if (!tgt_e[`MAL_E_STATIC]) begin
                mem_ff[{bkt, tgt}] <= {tgt_e[71:69], `MAL_AGE_DEFAULT, tgt_e[65:62],
                                       learn_fwd, tgt_e[54:0]};
                lru_ff[bkt] <= touch(lru_ff[bkt], tgt);
              end
            end else if (!tgt_ok) begin
              lfail_ff <= 1'b1;
              eidx1_ff <= bkt;
            end else begin
              mem_ff[{bkt, tgt}] <= {3'h0, `MAL_AGE_DEFAULT, 4'h0, learn_fwd,
                                     learn_fid, learn_mac};
              lru_ff[bkt] <= touch(lru_ff[bkt], tgt);
            end
          end else if (age_tick) begin
            ptr_ff <= {AW{1'b0}};
            st_ff <= S_AGE;
          end
        end
        S_SRCH: begin
          if (!go_ff) begin
            st_ff <= S_IDLE;
          end else if (ent_ok(pe)) begin
            ent_ff <= pe;
            found_ff <= 1'b1;
            cnt_ff <= cnt_ff + 13'h0001;
            st_ff <= S_SHOW;
          end else if (ptr_end) begin
            go_ff <= 1'b0;
            ent_ff <= {EW{1'b0}};
            found_ff <= 1'b0;
            st_ff <= S_IDLE;
          end else begin
            ptr_ff <= ptr_ff + {{(AW-1){1'b0}}, 1'b1};
          end
        end
        S_SHOW: begin
          if (!go_ff) begin
            st_ff <= S_IDLE;
          end else if (ent4_rd) begin
            found_ff <= 1'b0;
            if (ptr_end) begin
              go_ff <= 1'b0;
              ent_ff <= {EW{1'b0}};
              st_ff <= S_IDLE;
            end else begin
              ptr_ff <= ptr_ff + {{(AW-1){1'b0}}, 1'b1};
              st_ff <= S_SRCH;
            end
          end
        end
        S_AGE: begin
          if (!pe[`MAL_E_STATIC] && pe[68:66] != 3'h0)
            mem_ff[ptr_ff] <= {pe[71:69], pe[68:66] - 3'h1, pe[65:0]};
          if (ptr_end)
            st_ff <= S_IDLE;
          else
            ptr_ff <= ptr_ff + {{(AW-1){1'b0}}, 1'b1};
        end
        default: st_ff <= S_IDLE;
      endcase
      // Host register writes take effect last
      if (reg_wr) begin
        case (reg_addr)
          `MAL_OFS_IDX0: begin
            idx_fid_ff <= reg_wdata[22:16];
            idx_hi_ff <= reg_wdata[15:0];
          end
          `MAL_OFS_IDX1: idx_lo_ff <= reg_wdata;
          `MAL_OFS_CTRL: begin
            go_ff <= reg_wdata[`MAL_CTL_GO];
            op_ff <= reg_wdata[`MAL_CTL_OP_HI:`MAL_CTL_OP_LO];
            dir_ff <= reg_wdata[`MAL_CTL_DIRECT];
          end
          `MAL_OFS_ENT1: begin
            ent_ff[71:66] <= reg_wdata[31:26];
            ent_ff[65:63] <= reg_wdata[2:0];
          end
          `MAL_OFS_ENT2: begin
            ent_ff[62] <= reg_wdata[31];
            ent_ff[61:55] <= reg_wdata[6:0];
          end
          `MAL_OFS_ENT3: ent_ff[54:32] <= reg_wdata[22:0];
          `MAL_OFS_ENT4: ent_ff[31:0] <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `MAL_OFS_EIDX0: rdata_ff <= {{(32-AW){1'b0}}, eidx0_ff};
        `MAL_OFS_EIDX1: rdata_ff <= {{(32-BKT_W){1'b0}}, eidx1_ff};
        `MAL_OFS_IDX0: rdata_ff <= {9'h000, idx_fid_ff, idx_hi_ff};
        `MAL_OFS_IDX1: rdata_ff <= idx_lo_ff;
        `MAL_OFS_CTRL: rdata_ff <= {go_ff, found_ff, found_ff | ~go_ff, op_ff, dir_ff,
                                    13'h0000, cnt_ff};
        `MAL_OFS_ENT1: rdata_ff <= {ent_ff[71:66], 23'h000000, ent_ff[65:63]};
        `MAL_OFS_ENT2: rdata_ff <= {ent_ff[62], 24'h000000, ent_ff[61:55]};
        `MAL_OFS_ENT3: rdata_ff <= {9'h000, ent_ff[54:32]};
        `MAL_OFS_ENT4: rdata_ff <= ent_ff[31:0];
        default: rdata_ff <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Destination lookup
  // ----------------------------------------------------------------------
  wire [BKT_W-1:0] d_bkt;
  mal_hash #(.IW(BKT_W)) u_dhash (
    .mac(dst_mac),
    .filter_group_id(dst_fid),
    .use_fid(vlan_en),
    .opt(hash_option),
    .idx(d_bkt)
  );
  wire [4*EW-1:0] d_bk = {mem_ff[{d_bkt, 2'h3}], mem_ff[{d_bkt, 2'h2}],
                          mem_ff[{d_bkt, 2'h1}], mem_ff[{d_bkt, 2'h0}]};
  wire [2:0] d_hit = find_way(d_bk, dst_mac, dst_fid, vlan_en);
  wire [EW-1:0] d_e = d_bk[d_hit[1:0]*EW +: EW];

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dst_done_ff <= 1'b0;
      dst_hit_ff <= 1'b0;
      dst_static_ff <= 1'b0;
      dst_drop_ff <= 1'b0;
      dst_fwd_ff <= 7'h00;
    end else begin
      dst_done_ff <= dst_req;
      if (dst_req) begin
        if (sat_hit && !(d_hit[2] && d_e[`MAL_E_STATIC])) begin
          dst_hit_ff <= 1'b1;
          dst_static_ff <= 1'b1;
          dst_drop_ff <= 1'b0;
          dst_fwd_ff <= sat_fwd;
        end else if (d_hit[2]) begin
          dst_hit_ff <= 1'b1;
          dst_static_ff <= d_e[`MAL_E_STATIC];
          dst_drop_ff <= d_e[`MAL_E_DDROP];
          dst_fwd_ff <= d_e[`MAL_E_FWD_HI:`MAL_E_FWD_LO];
        end else begin
          dst_hit_ff <= 1'b0;
          dst_static_ff <= 1'b0;
          dst_drop_ff <= 1'b0;
          dst_fwd_ff <= 7'h00;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = rdata_ff;
  assign learn_ack = learn_ack_ff;
  assign src_drop = src_drop_ff;
  assign dst_done = dst_done_ff;
  assign dst_hit = dst_hit_ff;
  assign dst_static = dst_static_ff;
  assign dst_drop = dst_drop_ff;
  assign dst_fwd = dst_fwd_ff;
  assign almost_full = almost_ff;
  assign write_fail = wfail_ff;
  assign learn_fail = lfail_ff;
endmodule // mal_top

// >>> mal_checker.sv
// Port checker for the MAC address lookup table top level.
// Assumes it is bound to mal_top and sees only that module's ports.
`include "mal_regs.vh"
module mal_checker (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Register port
  input wire [15:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Learning and lookup
  input wire learn_req,
  input wire learn_ack,
  input wire src_drop,
  input wire dst_req,
  input wire sat_hit,
  input wire dst_done,
  input wire dst_hit,
  input wire dst_static,
  // Events
  input wire almost_full,
  input wire write_fail,
  input wire learn_fail
);
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_dst_answer: assert property (dst_req |=> dst_done) else $error("lookup unanswered");
  a_dst_cause: assert property (dst_done |-> $past(dst_req)) else $error("stray answer");
  a_static_wins: assert property (dst_req && sat_hit |=> dst_hit && dst_static)
    else $error("static result lost");
  a_fail_with_ack: assert property (learn_fail |-> learn_ack) else $error("fail no ack");
  a_ack_cause: assert property (learn_ack |-> $past(learn_req)) else $error("stray ack");
  a_drop_holds: assert property (!learn_ack |-> $stable(src_drop)) else $error("drop moved");
  a_event_excl: assert property (!(almost_full && write_fail)) else $error("both events");
  a_fod_bit: assert property (reg_rd && reg_addr == `MAL_OFS_CTRL |=>
    reg_rdata[29] == (reg_rdata[30] || !reg_rdata[31])) else $error("found-or-done wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 16'h0408 |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
endmodule // mal_checker

bind mal_top mal_checker u_chk (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .learn_req(learn_req), .learn_ack(learn_ack),
  .src_drop(src_drop), .dst_req(dst_req), .sat_hit(sat_hit), .dst_done(dst_done),
  .dst_hit(dst_hit), .dst_static(dst_static), .almost_full(almost_full),
  .write_fail(write_fail), .learn_fail(learn_fail));

// >>> tb.sv
// Self-checking bench of the lookup table through its register, learn and lookup ports.
// Assumes mal_top with BKT_W 4, hash option 2 using the low MAC bits, checker bound.
`include "mal_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  wire [31:0] reg_rdata;
  logic [1:0] hash_option = 2'h2;
  logic vlan_en = 1'b0;
  logic learn_req = 1'b0;
  logic [47:0] learn_mac = 48'h0;
  logic [6:0] learn_fid = 7'h0;
  logic [2:0] learn_port = 3'h0;
  wire learn_ack, src_drop, learn_fail, almost_full, write_fail;
  logic dst_req = 1'b0;
  logic [47:0] dst_mac = 48'h0;
  logic [6:0] dst_fid = 7'h0;
  logic sat_hit = 1'b0;
  logic [6:0] sat_fwd = 7'h0;
  wire dst_done, dst_hit, dst_static, dst_drop;
  wire [6:0] dst_fwd;
  logic age_tick = 1'b0;
  int fails = 0;
  int checked = 0;
  int n_af = 0, n_wf = 0, n_lf = 0, n_ack = 0, cnt, n;
  logic [31:0] rq[$], mq[$], v;
  logic [9:0] dq[$], dmq[$];
  logic rd_pend = 1'b0;
  logic [47:0] mac[0:5];
  logic [2:0] p;
  mal_top #(.BKT_W(4)) dut (.*);
  always #10 mclk = ~mclk;
  // ----------------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------------
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    checked++;
    if ((got & m) !== (e & m)) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got & m, e & m);
    end
  endtask
  task automatic cmp_dst(input logic [9:0] got, input logic [9:0] e, input logic [9:0] m);
    checked++;
    if ((got & m) !== (e & m)) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got & m, e & m);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back(e);
    mq.push_back(m);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic poll();
    n = 0;
    do begin
      rd(`MAL_OFS_CTRL, 32'h0, 32'h0);
      n++;
    end while (v[`MAL_CTL_FOD] !== 1'b1 && n < 100);
    if (n >= 100) fails++;
  endtask
  task automatic run_op(input logic [1:0] op, input logic dir);
    wr(`MAL_OFS_CTRL, {1'b1, 2'b00, op, dir, 26'h0});
    poll();
  endtask
  task automatic lookup_key(input logic [47:0] m, input logic dir);
    wr(`MAL_OFS_IDX0, {16'h0, m[47:32]});
    wr(`MAL_OFS_IDX1, m[31:0]);
    run_op(`MAL_OP_READ, dir);
  endtask
  task automatic learn(input logic [47:0] m, input logic [2:0] pt);
    @(posedge mclk);
    learn_req <= 1'b1;
    learn_mac <= m;
    learn_port <= pt;
    @(posedge mclk);
    learn_req <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic dl(input logic [47:0] m, input logic sh, input logic [6:0] sf,
                    input logic [9:0] e, input logic [9:0] mk);
    dq.push_back(e);
    dmq.push_back(mk);
    @(posedge mclk);
    dst_req <= 1'b1;
    dst_mac <= m;
    sat_hit <= sh;
    sat_fwd <= sf;
    @(posedge mclk);
    dst_req <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------------
  always @(posedge mclk) rd_pend <= reg_rd;
  always @(negedge mclk) begin
    if (rd_pend) cmp_word(reg_rdata, rq.pop_front(), mq.pop_front());
    if (dst_done) cmp_dst({dst_hit, dst_static, dst_drop, dst_fwd}, dq.pop_front(), dmq.pop_front());
    if (almost_full) n_af++;
    if (write_fail) n_wf++;
    if (learn_fail) n_lf++;
    if (learn_ack) n_ack++;
  end
  initial begin
    #(20 * 30000);
    fails++;
    give_verdict();
  end
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    v = $urandom(56);
    for (int i = 0; i < 6; i++) mac[i] = {8'h0a, 8'(i), $urandom() & 32'hffff_fff0 | 32'h5};
    mac[5][3:0] = 4'h7;
    p = 3'($urandom() % 7);
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`MAL_OFS_CTRL, 32'h2000_0000, 32'hffff_ffff);
    rd(16'h0408, 32'h0, 32'hffff_ffff);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(`MAL_OFS_ENT1, (i == 0) ? 32'he800_0001 : 32'h8800_0001);
      wr(`MAL_OFS_ENT2, {25'h0, 7'(8'h11 + i)});
      wr(`MAL_OFS_ENT3, {16'h0, mac[i][47:32]});
      wr(`MAL_OFS_ENT4, mac[i][31:0]);
      run_op(`MAL_OP_WRITE, 1'b0);
      if (i == 3) rd(`MAL_OFS_EIDX0, 32'h14, 32'hffc);
      if (i == 4) rd(`MAL_OFS_EIDX0, 32'h5, 32'h3ff);
    end
    cmp_word(n_af, 32'h2, 32'hffff_ffff);
    cmp_word(n_wf, 32'h1, 32'hffff_ffff);
    $display("test static fill done");
    lookup_key(mac[1], 1'b0);
    rd(`MAL_OFS_CTRL, 32'h6000_0000, 32'he000_0000);
    rd(`MAL_OFS_ENT1, 32'h8800_0001, 32'hffff_ffff);
    rd(`MAL_OFS_ENT2, 32'h12, 32'h7f);
    rd(`MAL_OFS_ENT4, mac[1][31:0], 32'hffff_ffff);
    lookup_key(48'h14, 1'b1);
    rd(`MAL_OFS_ENT1, 32'h8000_0000, 32'h8000_0000);
    lookup_key(mac[4], 1'b0);
    for (int k = 0; k < 4; k++) rd(16'(`MAL_OFS_ENT1 + 4 * k), 32'h0, 32'hffff_ffff);
    $display("test read done");
    learn({16'h0b00, mac[0][31:0]}, p);
    learn(mac[5], p);
    rd(`MAL_OFS_EIDX1, 32'h5, 32'h3ff);
    cmp_word(n_lf, 32'h1, 32'hffff_ffff);
    cmp_word(n_ack, 32'h2, 32'hffff_ffff);
    learn(mac[0], p);
    cmp_word(src_drop, 32'h1, 32'hffff_ffff);
    dl(mac[0], 1'b0, 7'h0, {3'b111, 7'h11}, 10'h3ff);
    dl(mac[5], 1'b0, 7'h0, {3'b100, 7'(8'h1 << p)}, 10'h3ff);
    dl(mac[5], 1'b1, 7'h2a, {3'b110, 7'h2a}, 10'h37f);
    dl(mac[1], 1'b1, 7'h2a, {3'b110, 7'h12}, 10'h37f);
    $display("test learn and lookup done");
    wr(`MAL_OFS_CTRL, {1'b1, 2'b00, `MAL_OP_SEARCH, 27'h0});
    cnt = 0;
    for (int k = 0; k < 20; k++) begin
      poll();
      if (v[`MAL_CTL_GO] !== 1'b1) break;
      cnt++;
      for (int j = 0; j < 4; j++)
        rd(16'(`MAL_OFS_ENT1 + 4 * j), mac[(k < 4) ? k : 5][31:0], {32{j == 3}});
    end
    cmp_word(cnt, 32'h5, 32'hffff_ffff);
    rd(`MAL_OFS_CTRL, 32'h5, 32'h1fff);
    wr(`MAL_OFS_CTRL, {1'b1, 2'b00, `MAL_OP_SEARCH, 27'h0});
    wr(`MAL_OFS_CTRL, 32'h0);
    rd(`MAL_OFS_CTRL, 32'h0, 32'h8000_0000);
    $display("test search done");
    repeat (8) begin
      @(posedge mclk);
      age_tick <= 1'b1;
      @(posedge mclk);
      age_tick <= 1'b0;
      repeat (80) @(posedge mclk);
    end
    dl(mac[5], 1'b0, 7'h0, 10'h0, 10'h200);
    dl(mac[2], 1'b0, 7'h0, {3'b110, 7'h13}, 10'h37f);
    $display("test aging done");
    give_verdict();
  end
endmodule // tb
